// file: design/mcc_cfg.svh
// offsets, field positions, reset values and timing counts
`ifndef MCC_CFG_SVH
`define MCC_CFG_SVH
`define MCC_ADDR_W          8
`define MCC_OFF_CTRL        8'h6c
`define MCC_OFF_IPERR       8'h70
`define MCC_OFF_STAT        8'h74
`define MCC_OFF_MASK        8'h78
`define MCC_OFF_TAG         8'h7c
`define MCC_OFF_CSERR       8'h80
`define MCC_OFF_THR         8'h84
`define MCC_CTRL_RST        32'h00000000
`define MCC_CTRL_WMASK      32'h00003fe3
`define MCC_B_FDX           5
`define MCC_B_BIG           6
`define MCC_B_PSEND         7
`define MCC_B_POBEY         8
`define MCC_B_KEEPCRC       9
`define MCC_B_BUFLB         10
`define MCC_B_MACLB         11
`define MCC_B_TAGINS        12
`define MCC_B_TAGSTRIP      13
`define MCC_B_STATEN        21
`define MCC_B_STATDIS       22
`define MCC_B_STATON        23
`define MCC_B_NEAROVF       7
`define MCC_B_MASK_IPERR    0
`define MCC_IPERR_MAX       16'hffff
`define MCC_IPERR_NEAR      16'hc000
`define MCC_GAP_96          13'd96
`define MCC_GAP_1024        13'd1024
`define MCC_GAP_1792        13'd1792
`define MCC_GAP_4352        13'd4352
`define MCC_MAX_STD         13'd1514
`define MCC_MAX_BIG         13'd4491
`endif

// file: design/mcc_pkg.sv
// types for the mac control slice
package mcc_pkg;
	typedef enum logic [1:0] {
		MCC_GAP_STD = 2'b00,
		MCC_GAP_1K  = 2'b01,
		MCC_GAP_2K  = 2'b10,
		MCC_GAP_4K  = 2'b11
	} mcc_gap_t;
	typedef enum logic [1:0] {
		MCC_IDLE  = 2'b00,
		MCC_RDATA = 2'b01
	} mcc_bus_t;
endpackage

// file: design/mcc_top.sv
// mac control word, ip checksum error counter and derived line controls
// Overview of operation
// - count each received frame failing the ipv4 header checksum
// - the 16-bit error counter wraps from 0xffff to zero
// - counter reaching 0xc000 sets the near-overflow status flag
// - counting needs statistics enabled and this counter's mask bit set
// - gap select bits 1:0 choose 96, 1024, 1792 or 4352 bit times
// - selected gap applies in half duplex when deferring after collision
// - bit 5 selects half (0) or full (1) duplex
// - full duplex disables transmit deferral to receive activity
// - full duplex freezes the carrier-sense error counter
// - bit 6 picks oversize threshold 1514 or 4491 bytes
// - oversize length counts addresses, type/length and fcs
// - bit 7 enables automatic pause sending from fifo thresholds
// - bit 8 clear passes pause frames as data, set obeys them
// - bit 9 keeps received fcs in fifo; checking unchanged
// - bit 10 loops transmit fifo output into receive fifo input
// - bit 11 loops mac transmit output into mac receive input
// - bit 12 inserts the programmed vlan tag on every sent frame
// - bit 13 strips any vlan tag from every received frame
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps
`include "mcc_cfg.svh"
module mcc_top
	import mcc_pkg::*;
(
	// clock and reset
	input  wire logic        REF_CLK_IN,
	input  wire logic        RESETN_IN,
	// avalon-mm slave
	input  wire logic [7:0]  AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	input  wire logic [3:0]  AVS_BYTEENABLE_IN,
	output logic      [31:0] AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	// receive side events
	input  wire logic        RX_FRAME_DONE_IN,
	input  wire logic        RX_IP_PRESENT_IN,
	input  wire logic        RX_IP_CSUM_BAD_IN,
	input  wire logic        RX_CARRIER_ERR_IN,
	input  wire logic [12:0] RX_FRAME_LEN_IN,
	input  wire logic        RX_IS_PAUSE_IN,
	// transmit side status
	input  wire logic        COLLISION_DEFER_IN,
	input  wire logic        RX_ACTIVE_IN,
	input  wire logic [15:0] RX_FIFO_LEVEL_IN,
	// line controls
	output logic      [12:0] GAP_BITS_OUT,
	output logic             FULL_DUPLEX_OUT,
	output logic             DEFER_TO_RX_OUT,
	output logic             FRAME_TOO_LONG_OUT,
	output logic             PAUSE_REQUEST_OUT,
	output logic             PAUSE_OBEY_OUT,
	output logic             KEEP_CRC_FIELD_OUT,
	output logic             BUFFER_LOOPBACK_OUT,
	output logic             MAC_CORE_LOOPBACK_OUT,
	output logic             TAG_INSERT_OUT,
	output logic [15:0]      INSERT_TAG_VALUE_OUT,
	output logic             TAG_STRIP_OUT
);
	logic [31:0] mac_control_word;
	logic        stats_count_enable;
	logic [15:0] ip_header_check_fail_count;
	logic [15:0] carrier_loss_count;
	logic [31:0] stats_mask_reg;
	logic [31:0] interrupt_status_reg;
	logic [15:0] insert_tag_value;
	logic [15:0] resume_threshold;
	logic [15:0] halt_threshold;
	logic        stats_near_overflow;
	logic        pausing;
	mcc_bus_t    bus_state;
	mcc_gap_t    gap_length_select;
	logic [31:0] be_mask;
	logic [31:0] next_rdata;
	logic        wr_go;
	logic        rd_go;
	logic        ip_fail_evt;
	logic        ip_near_hit;
	logic [15:0] next_ip_count;
	logic        clr_status;
	logic        full_duplex_select;
	logic        big_frame_accept;
	logic [12:0] max_len;

	assign be_mask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
		{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
	assign wr_go = AVS_WRITE_IN && (bus_state == MCC_IDLE);
	assign rd_go = AVS_READ_IN && (bus_state == MCC_IDLE);
	// writes answer at once, reads after one registered cycle
	assign AVS_WAITREQUEST_OUT = AVS_READ_IN && (bus_state == MCC_IDLE);

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			bus_state <= MCC_IDLE;
		end else if (rd_go) begin
			bus_state <= MCC_RDATA;
		end else begin
			bus_state <= MCC_IDLE;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h00000000;
		case (AVS_ADDRESS_IN)
			`MCC_OFF_CTRL: begin
				next_rdata = mac_control_word;
				next_rdata[`MCC_B_STATON] = stats_count_enable;
			end
			`MCC_OFF_IPERR: next_rdata = {16'h0000, ip_header_check_fail_count};
			`MCC_OFF_STAT:  next_rdata = interrupt_status_reg;
			`MCC_OFF_MASK:  next_rdata = stats_mask_reg;
			`MCC_OFF_TAG:   next_rdata = {16'h0000, insert_tag_value};
			`MCC_OFF_CSERR: next_rdata = {16'h0000, carrier_loss_count};
			`MCC_OFF_THR:   next_rdata = {halt_threshold, resume_threshold};
			default:        next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			AVS_READDATA_OUT <= 32'h00000000;
		end else if (rd_go) begin
			AVS_READDATA_OUT <= next_rdata;
		end
	end

	// control word: only implemented bits store, strobes self-clear
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			mac_control_word <= `MCC_CTRL_RST;
		end else if (wr_go && AVS_ADDRESS_IN == `MCC_OFF_CTRL) begin
			mac_control_word <= (mac_control_word & ~(be_mask & `MCC_CTRL_WMASK))
				| (AVS_WRITEDATA_IN & be_mask & `MCC_CTRL_WMASK);
		end
	end

	// statistics enable and disable strobes
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			stats_count_enable <= 1'b0;
		end else if (wr_go && AVS_ADDRESS_IN == `MCC_OFF_CTRL
				&& AVS_BYTEENABLE_IN[2]) begin
			if (AVS_WRITEDATA_IN[`MCC_B_STATDIS]) begin
				stats_count_enable <= 1'b0;
			end else if (AVS_WRITEDATA_IN[`MCC_B_STATEN]) begin
				stats_count_enable <= 1'b1;
			end
		end
	end

	// plain registers: mask, tag, thresholds
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			stats_mask_reg   <= 32'h00000000;
			insert_tag_value <= 16'h0000;
			resume_threshold <= 16'h0000;
			halt_threshold   <= 16'h0000;
		end else if (wr_go) begin
			case (AVS_ADDRESS_IN)
				`MCC_OFF_MASK: stats_mask_reg <= (stats_mask_reg & ~be_mask)
					| (AVS_WRITEDATA_IN & be_mask);
				`MCC_OFF_TAG: insert_tag_value <=
					(insert_tag_value & ~be_mask[15:0])
					| (AVS_WRITEDATA_IN[15:0] & be_mask[15:0]);
				`MCC_OFF_THR: begin
					resume_threshold <= (resume_threshold & ~be_mask[15:0])
						| (AVS_WRITEDATA_IN[15:0] & be_mask[15:0]);
					halt_threshold <= (halt_threshold & ~be_mask[31:16])
						| (AVS_WRITEDATA_IN[31:16] & be_mask[31:16]);
				end
				default: stats_mask_reg <= stats_mask_reg;
			endcase
		end
	end

	// ip checksum error counter
	assign ip_fail_evt = RX_FRAME_DONE_IN && RX_IP_PRESENT_IN
		&& RX_IP_CSUM_BAD_IN
		&& stats_count_enable && stats_mask_reg[`MCC_B_MASK_IPERR];
	assign next_ip_count = (ip_header_check_fail_count == `MCC_IPERR_MAX)
		? 16'h0000 : ip_header_check_fail_count + 16'h0001;
	assign ip_near_hit = ip_fail_evt && (next_ip_count == `MCC_IPERR_NEAR);

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ip_header_check_fail_count <= 16'h0000;
		end else if (ip_fail_evt) begin
			ip_header_check_fail_count <= next_ip_count;
		end else if (wr_go && AVS_ADDRESS_IN == `MCC_OFF_IPERR) begin
			ip_header_check_fail_count <=
				(ip_header_check_fail_count & ~be_mask[15:0])
				| (AVS_WRITEDATA_IN[15:0] & be_mask[15:0]);
		end
	end

	// carrier-sense error counter, frozen in full duplex
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			carrier_loss_count <= 16'h0000;
		end else if (RX_CARRIER_ERR_IN && stats_count_enable
				&& !full_duplex_select) begin
			carrier_loss_count <= carrier_loss_count + 16'h0001;
		end
	end

	// near-overflow flag: set wins over clear, write one to clear
	assign clr_status = wr_go && AVS_ADDRESS_IN == `MCC_OFF_STAT
		&& AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[`MCC_B_NEAROVF];
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			stats_near_overflow <= 1'b0;
		end else if (ip_near_hit) begin
			stats_near_overflow <= 1'b1;
		end else if (clr_status) begin
			stats_near_overflow <= 1'b0;
		end
	end
	always_comb begin
		interrupt_status_reg = 32'h00000000;
		interrupt_status_reg[`MCC_B_NEAROVF] = stats_near_overflow;
	end

	// control fields
	assign gap_length_select  = mcc_gap_t'(mac_control_word[1:0]);
	assign full_duplex_select = mac_control_word[`MCC_B_FDX];
	assign big_frame_accept   = mac_control_word[`MCC_B_BIG];

	// inter-frame gap, held at standard unless deferring in half duplex
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			GAP_BITS_OUT <= `MCC_GAP_96;
		end else if (!full_duplex_select && COLLISION_DEFER_IN) begin
			case (gap_length_select)
				MCC_GAP_STD: GAP_BITS_OUT <= `MCC_GAP_96;
				MCC_GAP_1K:  GAP_BITS_OUT <= `MCC_GAP_1024;
				MCC_GAP_2K:  GAP_BITS_OUT <= `MCC_GAP_1792;
				MCC_GAP_4K:  GAP_BITS_OUT <= `MCC_GAP_4352;
				default:     GAP_BITS_OUT <= `MCC_GAP_96;
			endcase
		end else begin
			GAP_BITS_OUT <= `MCC_GAP_96;
		end
	end

	// oversize check on da+sa+type/len+fcs length
	assign max_len = big_frame_accept ? `MCC_MAX_BIG : `MCC_MAX_STD;
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			FRAME_TOO_LONG_OUT <= 1'b0;
		end else if (RX_FRAME_DONE_IN) begin
			FRAME_TOO_LONG_OUT <= (RX_FRAME_LEN_IN >= max_len);
		end else begin
			FRAME_TOO_LONG_OUT <= 1'b0;
		end
	end

	// pause request hysteresis on receive fifo level
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			pausing <= 1'b0;
		end else if (!mac_control_word[`MCC_B_PSEND]) begin
			pausing <= 1'b0;
		end else if (RX_FIFO_LEVEL_IN >= halt_threshold) begin
			pausing <= 1'b1;
		end else if (RX_FIFO_LEVEL_IN <= resume_threshold) begin
			pausing <= 1'b0;
		end
	end

	// registered line controls
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			FULL_DUPLEX_OUT       <= 1'b0;
			DEFER_TO_RX_OUT       <= 1'b0;
			PAUSE_REQUEST_OUT     <= 1'b0;
			PAUSE_OBEY_OUT        <= 1'b0;
			KEEP_CRC_FIELD_OUT    <= 1'b0;
			BUFFER_LOOPBACK_OUT   <= 1'b0;
			MAC_CORE_LOOPBACK_OUT <= 1'b0;
			TAG_INSERT_OUT        <= 1'b0;
			INSERT_TAG_VALUE_OUT  <= 16'h0000;
			TAG_STRIP_OUT         <= 1'b0;
		end else begin
			FULL_DUPLEX_OUT       <= full_duplex_select;
			DEFER_TO_RX_OUT       <= RX_ACTIVE_IN && !full_duplex_select;
			PAUSE_REQUEST_OUT     <= pausing;
			// pause frames reach the obey logic only when set
			PAUSE_OBEY_OUT        <= mac_control_word[`MCC_B_POBEY]
				&& RX_IS_PAUSE_IN && RX_FRAME_DONE_IN;
			KEEP_CRC_FIELD_OUT    <= mac_control_word[`MCC_B_KEEPCRC];
			BUFFER_LOOPBACK_OUT   <= mac_control_word[`MCC_B_BUFLB];
			MAC_CORE_LOOPBACK_OUT <= mac_control_word[`MCC_B_MACLB];
			TAG_INSERT_OUT        <= mac_control_word[`MCC_B_TAGINS];
			INSERT_TAG_VALUE_OUT  <= insert_tag_value;
			TAG_STRIP_OUT         <= mac_control_word[`MCC_B_TAGSTRIP];
		end
	end
endmodule

// file: dv/mcc_sva.sv
// port assertions for the mac control slice
`timescale 1ns/10ps
module mcc_sva (
	// clock and reset
	input wire logic        REF_CLK_IN,
	input wire logic        RESETN_IN,
	// bus handshake
	input wire logic        AVS_READ_IN,
	input wire logic        AVS_WRITE_IN,
	input wire logic        AVS_WAITREQUEST_OUT,
	// line side
	input wire logic        RX_FRAME_DONE_IN,
	input wire logic        RX_IS_PAUSE_IN,
	input wire logic        RX_ACTIVE_IN,
	input wire logic        COLLISION_DEFER_IN,
	input wire logic [12:0] RX_FRAME_LEN_IN,
	input wire logic [12:0] GAP_BITS_OUT,
	input wire logic        FULL_DUPLEX_OUT,
	input wire logic        DEFER_TO_RX_OUT,
	input wire logic        FRAME_TOO_LONG_OUT,
	input wire logic        PAUSE_OBEY_OUT
);
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	gap_idle_a: assert property (
		!COLLISION_DEFER_IN |=> GAP_BITS_OUT == 13'd96)
		else $error("gap not standard without collision defer");
	gap_set_a: assert property (
		GAP_BITS_OUT inside {13'd96, 13'd1024, 13'd1792, 13'd4352})
		else $error("gap value outside the four choices");
	duplex_defer_a: assert property ($past(RESETN_IN) |->
		DEFER_TO_RX_OUT == ($past(RX_ACTIVE_IN) && !FULL_DUPLEX_OUT))
		else $error("defer to receive wrong for duplex mode");
	too_long_a: assert property (FRAME_TOO_LONG_OUT |->
		$past(RX_FRAME_DONE_IN) && $past(RX_FRAME_LEN_IN) >= 13'd1514)
		else $error("oversize flag without long frame");
	long_min_a: assert property (
		RX_FRAME_DONE_IN && RX_FRAME_LEN_IN >= 13'd4491
		|=> FRAME_TOO_LONG_OUT)
		else $error("frame above both limits not flagged");
	obey_src_a: assert property (PAUSE_OBEY_OUT |->
		$past(RX_FRAME_DONE_IN) && $past(RX_IS_PAUSE_IN))
		else $error("pause obey without pause frame");
	rd_wait_a: assert property ($rose(AVS_READ_IN) |->
		AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
		else $error("read wait state not exactly one cycle");
	wr_nowait_a: assert property (AVS_WRITE_IN |-> !AVS_WAITREQUEST_OUT)
		else $error("write stalled");
	cover property (FRAME_TOO_LONG_OUT);
	cover property (PAUSE_OBEY_OUT);
	cover property (COLLISION_DEFER_IN && GAP_BITS_OUT == 13'd4352);
endmodule

// file: dv/mcc_phy.sv
// media-side model driving receive frame events
`timescale 1ns/10ps
module mcc_phy (
	// clock
	input  wire logic        clk_in,
	// frame events
	output logic             done_out,
	output logic             ip_out,
	output logic             bad_out,
	output logic             pause_out,
	output logic [12:0]      len_out,
	output logic             cserr_out
);
	initial {done_out, ip_out, bad_out, pause_out, len_out, cserr_out} = '0;
	// end-of-frame strobe, qualifiers inverted once released
	task automatic frame(input logic [12:0] l, input logic [2:0] f);
		@(posedge clk_in);
		done_out <= 1'b1;
		len_out <= l;
		{ip_out, bad_out, pause_out} <= f;
		@(posedge clk_in);
		done_out <= 1'b0;
		len_out <= ~l;
		{ip_out, bad_out, pause_out} <= ~f;
	endtask
	task automatic carrier_err();
		@(posedge clk_in);
		cserr_out <= 1'b1;
		@(posedge clk_in);
		cserr_out <= 1'b0;
	endtask
endmodule

// file: dv/mac_control_config_tb_top.sv
// self-checking bench for the mac control slice
`timescale 1ns/10ps
module mac_control_config_tb_top;
	logic REF_CLK_IN = 0, RESETN_IN = 0, AVS_READ_IN = 0, AVS_WRITE_IN = 0;
	logic RX_ACTIVE_IN = 0, COLLISION_DEFER_IN = 0;
	logic [7:0]  AVS_ADDRESS_IN = '0;
	logic [31:0] AVS_WRITEDATA_IN = '0;
	logic [3:0]  AVS_BYTEENABLE_IN = 4'hf;
	logic [15:0] RX_FIFO_LEVEL_IN = '0;
	wire logic RX_FRAME_DONE_IN, RX_IP_PRESENT_IN, RX_IP_CSUM_BAD_IN;
	wire logic RX_IS_PAUSE_IN, RX_CARRIER_ERR_IN;
	wire logic [12:0] RX_FRAME_LEN_IN, GAP_BITS_OUT;
	wire logic [31:0] AVS_READDATA_OUT;
	wire logic [15:0] INSERT_TAG_VALUE_OUT;
	wire logic AVS_WAITREQUEST_OUT, FULL_DUPLEX_OUT, DEFER_TO_RX_OUT;
	wire logic FRAME_TOO_LONG_OUT, PAUSE_REQUEST_OUT, PAUSE_OBEY_OUT;
	wire logic KEEP_CRC_FIELD_OUT, BUFFER_LOOPBACK_OUT, MAC_CORE_LOOPBACK_OUT;
	wire logic TAG_INSERT_OUT, TAG_STRIP_OUT;
	int n_errors = 0;
	int checks_done = 0;
	logic [12:0] gaps [4] = '{13'd96, 13'd1024, 13'd1792, 13'd4352};
	logic [4:0]  lb;
	mcc_top uut (.*);
	mcc_phy phy (.clk_in(REF_CLK_IN), .done_out(RX_FRAME_DONE_IN),
		.ip_out(RX_IP_PRESENT_IN), .bad_out(RX_IP_CSUM_BAD_IN),
		.pause_out(RX_IS_PAUSE_IN), .len_out(RX_FRAME_LEN_IN),
		.cserr_out(RX_CARRIER_ERR_IN));
	always #10 REF_CLK_IN = ~REF_CLK_IN;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge REF_CLK_IN);
		AVS_ADDRESS_IN <= a;
		AVS_WRITEDATA_IN <= d;
		AVS_WRITE_IN <= w;
		AVS_READ_IN <= !w;
		// request held until the edge that samples waitrequest low
		do begin
			@(posedge REF_CLK_IN);
		end while (AVS_WAITREQUEST_OUT);
		q = AVS_READDATA_OUT;
		AVS_WRITE_IN <= 1'b0;
		AVS_READ_IN <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic settle();
		repeat (2) @(posedge REF_CLK_IN);
		#1;
	endtask
	task automatic fifo(input logic [15:0] v, input logic e);
		@(posedge REF_CLK_IN);
		RX_FIFO_LEVEL_IN <= v;
		settle();
		chk(PAUSE_REQUEST_OUT, e);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge REF_CLK_IN);
		RESETN_IN <= 1'b1;
		#1;
		chk(GAP_BITS_OUT, 32'd96);
		rd(8'h6c, 32'h0);
		wr(8'h78, 32'h1);
		phy.frame(13'd64, 3'b110);
		rd(8'h70, 32'h0);
		wr(8'h6c, 32'h200000);
		rd(8'h6c, 32'h800000);
		phy.frame(13'd64, 3'b110);
		phy.frame(13'd64, 3'b100);
		phy.frame(13'd64, 3'b010);
		rd(8'h70, 32'h1);
		wr(8'h78, 32'h0);
		phy.frame(13'd64, 3'b110);
		rd(8'h70, 32'h1);
		wr(8'h78, 32'h1);
		wr(8'h70, 32'hbfff);
		phy.frame(13'd64, 3'b110);
		rd(8'h70, 32'hc000);
		rd(8'h74, 32'h80);
		wr(8'h74, 32'h80);
		rd(8'h74, 32'h0);
		wr(8'h70, 32'hffff);
		phy.frame(13'd64, 3'b110);
		rd(8'h70, 32'h0);
		phy.carrier_err();
		rd(8'h80, 32'h1);
		wr(8'h6c, 32'h20);
		phy.carrier_err();
		rd(8'h80, 32'h1);
		@(posedge REF_CLK_IN);
		COLLISION_DEFER_IN <= 1'b1;
		RX_ACTIVE_IN <= 1'b1;
		for (int g = 0; g < 8; g++) begin
			wr(8'h6c, (32'(g[2]) << 5) | 32'(g[1:0]));
			settle();
			chk(GAP_BITS_OUT, g[2] ? 13'd96 : gaps[g[1:0]]);
			chk(FULL_DUPLEX_OUT, g[2]);
			chk(DEFER_TO_RX_OUT, !g[2]);
		end
		for (int b = 9; b < 14; b++) begin
			wr(8'h6c, 32'h1 << b);
			settle();
			lb = {TAG_STRIP_OUT, TAG_INSERT_OUT, MAC_CORE_LOOPBACK_OUT,
				BUFFER_LOOPBACK_OUT, KEEP_CRC_FIELD_OUT};
			chk(lb, 32'h1 << (b - 9));
			// statistics still enabled, so bit 23 reads back set
			rd(8'h6c, 32'h800000 | (32'h1 << b));
		end
		wr(8'h7c, 32'hdead8123);
		settle();
		chk(INSERT_TAG_VALUE_OUT, 32'h8123);
		rd(8'h7c, 32'h8123);
		wr(8'h6c, 32'hffffffff);
		rd(8'h6c, 32'h3fe3);
		rd(8'h90, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(8'h6c, 32'(i[1]) << 6);
			phy.frame(i[1] ? 13'd4490 + i[0] : 13'd1513 + i[0], 3'b000);
			#1;
			chk(FRAME_TOO_LONG_OUT, i[0]);
		end
		wr(8'h84, {16'd100, 16'd20});
		wr(8'h6c, 32'h1a0);
		phy.frame(13'd64, 3'b001);
		#1;
		chk(PAUSE_OBEY_OUT, 1'b1);
		fifo(16'd100, 1'b1);
		fifo(16'd50, 1'b1);
		fifo(16'd20, 1'b0);
		fifo(16'd99, 1'b0);
		fifo(16'd200, 1'b1);
		wr(8'h6c, 32'h20);
		settle();
		chk(PAUSE_REQUEST_OUT, 1'b0);
		phy.frame(13'd64, 3'b001);
		#1;
		chk(PAUSE_OBEY_OUT, 1'b0);
		wrap_up();
	end
endmodule
bind mcc_top mcc_sva chk_i (.*);
